// *** pkg/rts_defines.svh ***
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH
// Notes on behaviour
// R01 - settle count is 1024 oscillator input cycles
// R02 - settle count: crystal modes, power-on or wake only
// R03 - config bit enables brown-out; off means ignored
// R04 - low supply must persist qualify time to reset
// R05 - hold until supply recovers, then power-up delay
// R06 - low supply during delay restarts whole sequence
// R07 - brown-out enable forces power-up delay on
// R08 - power-on: delay, settle count, then release core
// R09 - master clear low past delays: release on rise
// R10 - cause bit 0 brown-out flag, cleared by brown-out
// R11 - cause bit 1 power-on flag, cleared on power-on
// R12 - power-on sets timeout and powerdown flags
// R13 - timeout/powerdown encoding per reset or wake kind
// R14 - resets load 000h; interrupt wake with enable 0004h
// R15 - registers reset on resets, kept on watchdog wake
// R16 - power-up delay holds core, power-on or brown-out
// R17 - detector outputs synchronised before use
// R18 - power-up delay length counted in slow-clock cycles

// ----------------------------------------
// timing
// ----------------------------------------
`define RTS_CLK_MHZ              100
`define RTS_OSC_SETTLE_CYCLES    1024
`define RTS_BOR_QUAL_TIME_US     100
`define RTS_BOR_QUAL_CYCLES      (`RTS_BOR_QUAL_TIME_US * `RTS_CLK_MHZ)
`define RTS_POWER_UP_DELAY_TIMER_TIME_US         72000
`define RTS_SLOW_CLK_KHZ         28
`define RTS_POWER_UP_DELAY_TIMER_SLOW_CYCLES     ((`RTS_POWER_UP_DELAY_TIMER_TIME_US * `RTS_SLOW_CLK_KHZ) / 1000)

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define RTS_OFS_CAUSE            8'h00
`define RTS_OFS_STATUS           8'h01
`define RTS_OFS_INT_STATUS       8'h02
`define RTS_OFS_INT_MASK         8'h03
`define RTS_CAUSE_BOR_BIT        0
`define RTS_CAUSE_POR_BIT        1
`define RTS_STAT_PD_BIT          3
`define RTS_STAT_TO_BIT          4
`define RTS_INT_W                6
`define RTS_INT_POR              0
`define RTS_INT_BOR              1
`define RTS_INT_WDT_RST          2
`define RTS_INT_MASTER_CLEAR_N             3
`define RTS_INT_WAKE             4
`define RTS_INT_RELEASE          5
`define RTS_PC_W                 13
`define RTS_RESET_VECTOR         13'h0000
`define RTS_IRQ_VECTOR           13'h0004
`endif

// *** pkg/rts_pkg.sv ***
package rts_pkg;
	typedef enum logic [1:0] {
		LOW_POWER_CRYSTAL_MODE  = 2'h0,
		MEDIUM_CRYSTAL_MODE     = 2'h1,
		HIGH_SPEED_CRYSTAL_MODE = 2'h2,
		RESISTOR_CAP_OSC_MODE   = 2'h3
	} osc_mode_t;

	typedef enum logic [3:0] {
		ST_DETECT = 4'h1,
		ST_POWER_UP_DELAY_TIMER   = 4'h2,
		ST_OST    = 4'h4,
		ST_RUN    = 4'h8
	} seq_state_t;

	typedef struct packed {
		osc_mode_t osc_mode;
		logic      brownout_enable_cfg;
		logic      power_up_delay_disable_n;
	} cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;
endpackage

// *** design/reset_timeout_sequencer.sv ***
`include "rts_defines.svh"

module reset_timeout_sequencer
	import rts_pkg::*;
#(
	parameter int BOR_QUAL_CYCLES   = `RTS_BOR_QUAL_CYCLES,
	parameter int POWER_UP_DELAY_TIMER_SLOW_CYCLES  = `RTS_POWER_UP_DELAY_TIMER_SLOW_CYCLES,
	parameter int OSC_SETTLE_CYCLES = `RTS_OSC_SETTLE_CYCLES
) (
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	input  wire logic                   clk_en,
	input  wire logic                   por_det_raw,
	input  wire logic                   brownout_det_raw,
	input  wire logic                   master_clear_n,
	input  wire logic                   oscillator_input,
	input  wire logic                   slow_osc_input,
	input  wire cfg_t                   cfg,
	input  wire logic                   sleep_active,
	input  wire logic                   watchdog_timer_expired,
	input  wire logic                   wake_irq,
	input  wire logic                   global_interrupt_enable,
	input  wire bus_req_t               bus_req,
	output logic [7:0]                  bus_rdata,
	output logic                        core_reset_hold,
	output logic                        regs_reset,
	output logic                        pc_load,
	output logic [`RTS_PC_W-1:0]        pc_load_value,
	output logic                        timeout_flag,
	output logic                        powerdown_flag,
	output logic                        irq
);
	localparam int QW = $clog2(BOR_QUAL_CYCLES + 1);
	localparam int PW = $clog2(POWER_UP_DELAY_TIMER_SLOW_CYCLES + 1);
	localparam int OW = $clog2(OSC_SETTLE_CYCLES + 1);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// bit order: por, brown-out, master clear, oscillator, slow oscillator
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic       osc_d_r;
	logic       slow_d_r;
	logic       master_clear_n_d_r;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_r <= 5'h04;
			sync2_r <= 5'h04;
		end else if (clk_en) begin
			sync1_r <= {por_det_raw, brownout_det_raw, master_clear_n,
				oscillator_input, slow_osc_input}; // [R17]
			sync2_r <= sync1_r; // [R17]
		end
	end

	wire por_s  = sync2_r[4];
	wire bor_s  = sync2_r[3];
	wire master_clear_n_s = sync2_r[2];

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			osc_d_r  <= 1'b0;
			slow_d_r <= 1'b0;
			master_clear_n_d_r <= 1'b1;
		end else if (clk_en) begin
			osc_d_r  <= sync2_r[1];
			slow_d_r <= sync2_r[0];
			master_clear_n_d_r <= master_clear_n_s;
		end
	end

	wire osc_rise  = sync2_r[1] & ~osc_d_r;
	wire slow_rise = sync2_r[0] & ~slow_d_r;
	wire master_clear_n_fall = master_clear_n_d_r & ~master_clear_n_s;

	// ----------------------------------------
	// brown-out qualification
	// ----------------------------------------
	logic [QW-1:0] qual_cnt_r;
	wire           bor_en  = cfg.brownout_enable_cfg;
	wire           bor_low = bor_s & bor_en; // [R03]

	always_ff @(posedge core_clk) begin
		if (!rstn || (clk_en && !bor_low)) begin
			qual_cnt_r <= '0;
		end else if (clk_en && qual_cnt_r != QW'(BOR_QUAL_CYCLES)) begin
			qual_cnt_r <= qual_cnt_r + QW'(1); // [R04]
		end
	end

	// ----------------------------------------
	// events
	// ----------------------------------------
	seq_state_t state_r;
	logic       hold_d_r;
	wire        bor_trip = bor_low && qual_cnt_r == QW'(BOR_QUAL_CYCLES - 1); // [R04]
	// a dip during the delay after a brown-out restarts it unqualified
	wire        bor_redip = bor_low && state_r == ST_POWER_UP_DELAY_TIMER; // [R06]
	wire        ev_por = por_s;
	wire        ev_bor = !por_s && (bor_trip || bor_redip);
	wire        norm = !por_s && !ev_bor;
	wire        ev_wdt_rst = norm && state_r == ST_RUN && watchdog_timer_expired && !sleep_active;
	wire        ev_wake = norm && state_r == ST_RUN && sleep_active && (watchdog_timer_expired || wake_irq);
	wire        wake_wdt = ev_wake && watchdog_timer_expired;
	wire        ev_master_clear_n = norm && master_clear_n_fall && !ev_wdt_rst && !ev_wake;
	wire        crystal = cfg.osc_mode != RESISTOR_CAP_OSC_MODE; // [R02]
	wire        power_up_delay_timer_on = !cfg.power_up_delay_disable_n || bor_en; // [R07]
	wire        hold = state_r != ST_RUN || !master_clear_n_s; // [R09]
	wire        ev_release = hold_d_r && !hold;

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	logic                 is_reset_r;
	logic                 ost_ok_r;
	logic                 power_up_delay_timer_req_r;
	logic                 by_bor_r;
	logic                 pc_do_r;
	logic [`RTS_PC_W-1:0] pc_vec_r;
	logic [PW-1:0]        power_up_delay_timer_cnt_r;
	logic [OW-1:0]        ost_cnt_r;
	wire                  power_up_delay_timer_done = slow_rise && power_up_delay_timer_cnt_r == PW'(POWER_UP_DELAY_TIMER_SLOW_CYCLES - 1); // [R18]
	wire                  ost_done = osc_rise && ost_cnt_r == OW'(OSC_SETTLE_CYCLES - 1); // [R01]

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_r    <= ST_DETECT;
			is_reset_r <= 1'b1;
			ost_ok_r   <= 1'b1;
			power_up_delay_timer_req_r <= 1'b1;
			by_bor_r   <= 1'b0;
			pc_do_r    <= 1'b1;
			pc_vec_r   <= `RTS_RESET_VECTOR;
		end else if (clk_en) begin
			if (ev_por || ev_bor) begin
				state_r    <= ST_DETECT; // [R05]
				is_reset_r <= 1'b1; // [R15]
				ost_ok_r   <= ev_por; // [R02]
				power_up_delay_timer_req_r <= 1'b1; // [R16]
				by_bor_r   <= ev_bor;
				pc_do_r    <= 1'b1;
				pc_vec_r   <= `RTS_RESET_VECTOR; // [R14]
			end else if (ev_wdt_rst || ev_master_clear_n) begin
				// master clear in a settle count keeps counting; the pin gates release
				// a watchdog reset must not rerun the settle count left armed by power-on
				if (ev_wdt_rst) begin
					state_r  <= ST_DETECT;
					ost_ok_r <= 1'b0; // [R02]
				end
				is_reset_r <= 1'b1; // [R15]
				pc_do_r    <= 1'b1;
				pc_vec_r   <= `RTS_RESET_VECTOR; // [R14]
			end else if (ev_wake) begin
				state_r    <= ST_DETECT;
				is_reset_r <= 1'b0; // [R15]
				ost_ok_r   <= 1'b1; // [R02]
				power_up_delay_timer_req_r <= 1'b0;
				by_bor_r   <= 1'b0;
				pc_do_r    <= wake_irq && !watchdog_timer_expired && global_interrupt_enable; // [R14]
				pc_vec_r   <= `RTS_IRQ_VECTOR; // [R14]
			end else begin
				case (state_r)
					ST_DETECT: begin
						if (ost_ok_r && !power_up_delay_timer_req_r) begin
							state_r <= crystal ? ST_OST : ST_RUN;
						end else if (!bor_low && power_up_delay_timer_req_r && (power_up_delay_timer_on || by_bor_r)) begin
							state_r <= ST_POWER_UP_DELAY_TIMER; // [R05] [R08]
						end else if (!bor_low) begin
							state_r <= (ost_ok_r && crystal) ? ST_OST : ST_RUN; // [R08]
						end
						if (!bor_low) begin
							power_up_delay_timer_req_r <= 1'b0;
						end
					end
					ST_POWER_UP_DELAY_TIMER: begin
						if (power_up_delay_timer_done) begin
							state_r <= (ost_ok_r && crystal) ? ST_OST : ST_RUN; // [R08]
						end
					end
					ST_OST: begin
						if (ost_done) begin
							state_r <= ST_RUN; // [R08]
						end
					end
					ST_RUN: begin
						state_r <= ST_RUN;
					end
					default: begin
						state_r <= ST_DETECT;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || (clk_en && state_r != ST_POWER_UP_DELAY_TIMER)) begin
			power_up_delay_timer_cnt_r <= '0; // [R06]
		end else if (clk_en && slow_rise) begin
			power_up_delay_timer_cnt_r <= power_up_delay_timer_cnt_r + PW'(1); // [R16]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || (clk_en && state_r != ST_OST)) begin
			ost_cnt_r <= '0;
		end else if (clk_en && osc_rise) begin
			ost_cnt_r <= ost_cnt_r + OW'(1); // [R01]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hold_d_r      <= 1'b1;
			pc_load_value <= `RTS_RESET_VECTOR;
		end else if (clk_en) begin
			hold_d_r      <= hold;
			pc_load_value <= pc_vec_r;
		end
	end

	assign core_reset_hold = hold; // [R16] [R09]
	assign regs_reset      = hold && is_reset_r; // [R15]
	// the value register follows pc_vec_r one cycle late; it is stable before release
	assign pc_load         = ev_release && pc_do_r; // [R14]

	// ----------------------------------------
	// timeout and powerdown flags
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			timeout_flag   <= 1'b1; // [R12]
			powerdown_flag <= 1'b1; // [R12]
		end else if (clk_en) begin
			if (ev_por || ev_bor) begin
				timeout_flag   <= 1'b1; // [R12] [R13]
				powerdown_flag <= 1'b1;
			end else if (ev_wdt_rst) begin
				timeout_flag   <= 1'b0; // [R13]
				powerdown_flag <= 1'b1;
			end else if (ev_wake) begin
				timeout_flag   <= !wake_wdt; // [R13]
				powerdown_flag <= 1'b0;
			end else if (ev_master_clear_n && sleep_active) begin
				timeout_flag   <= 1'b1; // [R13]
				powerdown_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [1:0]             cause_r;
	logic                   por_d_r;
	logic [`RTS_INT_W-1:0]  int_stat_r;
	logic [`RTS_INT_W-1:0]  int_mask_r;
	wire                    wr_cause = bus_req.wr && bus_req.addr == `RTS_OFS_CAUSE;
	wire [`RTS_INT_W-1:0]   int_set;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cause_r <= 2'h0; // [R11]
		end else if (clk_en) begin
			// hardware clears win over a software write in the same cycle
			if (ev_por) begin
				cause_r[`RTS_CAUSE_POR_BIT] <= 1'b0; // [R11]
			end else if (wr_cause) begin
				cause_r[`RTS_CAUSE_POR_BIT] <= bus_req.wdata[`RTS_CAUSE_POR_BIT]; // [R11]
			end
			if (ev_bor) begin
				cause_r[`RTS_CAUSE_BOR_BIT] <= 1'b0; // [R10]
			end else if (wr_cause) begin
				cause_r[`RTS_CAUSE_BOR_BIT] <= bus_req.wdata[`RTS_CAUSE_BOR_BIT]; // [R10]
			end
		end
	end

	assign int_set[`RTS_INT_POR]     = ev_por && !por_d_r;
	assign int_set[`RTS_INT_BOR]     = ev_bor;
	assign int_set[`RTS_INT_WDT_RST] = ev_wdt_rst;
	assign int_set[`RTS_INT_MASTER_CLEAR_N]    = ev_master_clear_n;
	assign int_set[`RTS_INT_WAKE]    = ev_wake;
	assign int_set[`RTS_INT_RELEASE] = ev_release;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			por_d_r    <= 1'b0;
			int_stat_r <= '0;
			int_mask_r <= '0;
		end else if (clk_en) begin
			por_d_r <= por_s;
			if (bus_req.wr && bus_req.addr == `RTS_OFS_INT_STATUS) begin
				int_stat_r <= (int_stat_r & ~bus_req.wdata[`RTS_INT_W-1:0]) | int_set;
			end else begin
				int_stat_r <= int_stat_r | int_set;
			end
			if (bus_req.wr && bus_req.addr == `RTS_OFS_INT_MASK) begin
				int_mask_r <= bus_req.wdata[`RTS_INT_W-1:0];
			end
		end
	end

	assign irq = |(int_stat_r & int_mask_r);

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			bus_rdata <= 8'h00;
		end else if (clk_en) begin
			bus_rdata <= 8'h00;
			if (bus_req.rd) begin
				case (bus_req.addr)
					`RTS_OFS_CAUSE:      bus_rdata <= {6'h00, cause_r};
					`RTS_OFS_STATUS:     bus_rdata <= {3'h0, timeout_flag, powerdown_flag, 3'h0};
					`RTS_OFS_INT_STATUS: bus_rdata <= {2'h0, int_stat_r};
					`RTS_OFS_INT_MASK:   bus_rdata <= {2'h0, int_mask_r};
					default:             bus_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule

// *** testbench/rts_core_model.sv ***
module rts_core_model
	import rts_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 osc_run,
	input  wire logic                 slow_run,
	input  wire logic                 pc_load,
	input  wire logic [12:0]          pc_load_value,
	output logic                      oscillator_input = 1'b0,
	output logic                      slow_osc_input = 1'b0,
	output logic [12:0]               last_pc = 13'h1FFF
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// oscillators stand still when stopped
	// ----------------------------------------
	always begin
		#20 oscillator_input = osc_run ? ~oscillator_input : 1'b0;
	end
	always begin
		#40 slow_osc_input = slow_run ? ~slow_osc_input : 1'b0;
	end
	// ----------------------------------------
	// core takes the vector only on the load pulse
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (pc_load)
			last_pc <= pc_load_value;
	end
endmodule

// *** testbench/rts_chk.sv ***
`include "rts_defines.svh"
module rts_chk
	import rts_pkg::*;
#(
	parameter int BOR_QUAL_CYCLES = 8
) (
	input wire logic                  core_clk,
	input wire logic                  rstn,
	input wire logic                  brownout_det_raw,
	input wire logic                  master_clear_n,
	input wire cfg_t                  cfg,
	input wire logic                  sleep_active,
	input wire logic                  watchdog_timer_expired,
	input wire logic                  core_reset_hold,
	input wire logic                  regs_reset,
	input wire logic                  pc_load,
	input wire logic [`RTS_PC_W-1:0]  pc_load_value,
	input wire logic                  timeout_flag,
	input wire logic                  powerdown_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	int lo_cnt;
	// saturates so a long brown-out never wraps
	always_ff @(posedge core_clk) begin
		if (!rstn || !brownout_det_raw || !cfg.brownout_enable_cfg)
			lo_cnt <= 0;
		else if (lo_cnt < 1000)
			lo_cnt <= lo_cnt + 1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_wdt_rst;
		watchdog_timer_expired && !sleep_active && !core_reset_hold && master_clear_n;
	endsequence
	sequence s_wdt_held;
		core_reset_hold && regs_reset && !timeout_flag && powerdown_flag;
	endsequence
	property p_por_flags;
		disable iff (1'b0) !rstn |=> timeout_flag && powerdown_flag && core_reset_hold;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("flags not set by power-on");
	property p_wdt_rst;
		s_wdt_rst |=> s_wdt_held ##1 (!core_reset_hold && pc_load);
	endproperty
	a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset sequence wrong");
	property p_wdt_wake;
		watchdog_timer_expired && sleep_active && !core_reset_hold |-> ##[1:3] (!timeout_flag && !powerdown_flag && !regs_reset);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");
	property p_bor;
		lo_cnt == BOR_QUAL_CYCLES + 6 |-> core_reset_hold && regs_reset;
	endproperty
	a_bor: assert property (p_bor) else $error("qualified brown-out did not reset");
	property p_pc_pulse;
		pc_load |=> !pc_load;
	endproperty
	a_pc_pulse: assert property (p_pc_pulse) else $error("pc load longer than one cycle");
	property p_pc_fall;
		pc_load && pc_load_value == `RTS_RESET_VECTOR |-> $fell(core_reset_hold);
	endproperty
	a_pc_fall: assert property (p_pc_fall) else $error("reset vector load not at release");
	property p_pc_vec;
		pc_load && $past(regs_reset) |-> pc_load_value == `RTS_RESET_VECTOR;
	endproperty
	a_pc_vec: assert property (p_pc_vec) else $error("reset loaded wrong vector");
	property p_rel_master_clear_n;
		$fell(core_reset_hold) |-> $past(master_clear_n, 2);
	endproperty
	a_rel_master_clear_n: assert property (p_rel_master_clear_n) else $error("release with master clear low");
endmodule
bind reset_timeout_sequencer rts_chk #(.BOR_QUAL_CYCLES(BOR_QUAL_CYCLES)) i_chk (
	.core_clk(core_clk), .rstn(rstn), .brownout_det_raw(brownout_det_raw), .master_clear_n(master_clear_n),
	.cfg(cfg), .sleep_active(sleep_active), .watchdog_timer_expired(watchdog_timer_expired),
	.core_reset_hold(core_reset_hold), .regs_reset(regs_reset), .pc_load(pc_load),
	.pc_load_value(pc_load_value), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

// *** testbench/reset_timeout_sequencer_test.sv ***
module reset_timeout_sequencer_test;
	import rts_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rstn = 1'b0, por_det_raw = 1'b0, brownout_det_raw = 1'b0;
	logic master_clear_n = 1'b1, sleep_active = 1'b0, watchdog_timer_expired = 1'b0, wake_irq = 1'b0;
	logic global_interrupt_enable = 1'b0, osc_run = 1'b1, slow_run = 1'b1, clk_en = 1'b1;
	logic oscillator_input, slow_osc_input, core_reset_hold, regs_reset, pc_load, timeout_flag, powerdown_flag, irq;
	logic [7:0]  bus_rdata;
	logic [12:0] pc_load_value, last_pc;
	cfg_t        cfg = '{RESISTOR_CAP_OSC_MODE, 1'b0, 1'b1};
	bus_req_t    bus_req = '0;
	int          errors = 0, n_compared = 0, k, i;
	cfg_t        tbl [6] = '{'{RESISTOR_CAP_OSC_MODE, 1'b0, 1'b1}, '{RESISTOR_CAP_OSC_MODE, 1'b0, 1'b0},
		'{RESISTOR_CAP_OSC_MODE, 1'b1, 1'b1}, '{LOW_POWER_CRYSTAL_MODE, 1'b0, 1'b1},
		'{MEDIUM_CRYSTAL_MODE, 1'b0, 1'b1}, '{HIGH_SPEED_CRYSTAL_MODE, 1'b0, 1'b1}};
	logic [5:0]  exp_hold = 6'b111110;
	always #5 core_clk = ~core_clk;
	reset_timeout_sequencer #(.BOR_QUAL_CYCLES(8), .POWER_UP_DELAY_TIMER_SLOW_CYCLES(4), .OSC_SETTLE_CYCLES(4)) i_dut (
		.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .por_det_raw(por_det_raw),
		.brownout_det_raw(brownout_det_raw), .master_clear_n(master_clear_n), .oscillator_input(oscillator_input),
		.slow_osc_input(slow_osc_input), .cfg(cfg), .sleep_active(sleep_active),
		.watchdog_timer_expired(watchdog_timer_expired), .wake_irq(wake_irq),
		.global_interrupt_enable(global_interrupt_enable), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.core_reset_hold(core_reset_hold), .regs_reset(regs_reset), .pc_load(pc_load), .pc_load_value(pc_load_value),
		.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));
	rts_core_model i_core (.core_clk(core_clk), .osc_run(osc_run), .slow_run(slow_run), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .oscillator_input(oscillator_input), .slow_osc_input(slow_osc_input),
		.last_pc(last_pc));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) bus_req <= {a, d, 2'b10};
		@(posedge core_clk) bus_req <= '0;
		// let the write land before the caller looks at its effect
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk) bus_req <= {a, 8'h00, 2'b01};
		@(posedge core_clk) bus_req <= '0;
		#1 chk(what, 16'(bus_rdata), 16'(exp));
	endtask
	task automatic wait_rel(input int lim);
		int n;
		n = 0;
		// always let one edge pass so a hold raised in this time step is seen
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (core_reset_hold !== 1'b0 && n < lim);
		chk("core released", 16'(core_reset_hold), 16'h0000);
	endtask
	task automatic por(input cfg_t c);
		@(posedge core_clk) cfg <= c;
		por_det_raw <= 1'b1;
		repeat (5) @(posedge core_clk);
		por_det_raw <= 1'b0;
	endtask
	task automatic pulse_wdt();
		@(posedge core_clk) watchdog_timer_expired <= 1'b1;
		@(posedge core_clk) watchdog_timer_expired <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("ERROR watchdog limit reached");
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		wait_rel(50);
		@(posedge core_clk) #1 chk("reset vector", 16'(last_pc), 16'h0000);
		rd(8'h00, 8'h00, "cause");
		rd(8'h01, 8'h18, "status");
		rd(8'h7F, 8'h00, "unmapped");
		$display("test power-on done");
		for (k = 0; k < 6; k++) begin
			osc_run <= 1'b0;
			slow_run <= 1'b0;
			por(tbl[k]);
			repeat (100) @(posedge core_clk);
			chk("stalled hold", 16'(core_reset_hold), 16'(exp_hold[k]));
			osc_run <= 1'b1;
			slow_run <= 1'b1;
			wait_rel(300);
		end
		$display("test delay modes done");
		master_clear_n <= 1'b0;
		por(tbl[5]);
		repeat (150) @(posedge core_clk);
		chk("held by clear", 16'(core_reset_hold), 16'h0001);
		master_clear_n <= 1'b1;
		wait_rel(6);
		$display("test master clear done");
		wr(8'h02, 8'h3F);
		wr(8'h03, 8'h04);
		rd(8'h02, 8'h00, "int status");
		pulse_wdt();
		wait_rel(10);
		rd(8'h01, 8'h08, "status");
		chk("irq", 16'(irq), 16'h0001);
		wr(8'h03, 8'h00);
		chk("irq masked", 16'(irq), 16'h0000);
		wr(8'h03, 8'h04);
		wr(8'h02, 8'h04);
		chk("irq cleared", 16'(irq), 16'h0000);
		$display("test watchdog reset done");
		sleep_active <= 1'b1;
		global_interrupt_enable <= 1'b1;
		@(posedge core_clk) wake_irq <= 1'b1;
		@(posedge core_clk) wake_irq <= 1'b0;
		for (i = 0; i < 100 && last_pc !== 13'h0004; i++)
			@(posedge core_clk);
		sleep_active <= 1'b0;
		chk("wake vector", 16'(last_pc), 16'h0004);
		rd(8'h01, 8'h10, "status");
		sleep_active <= 1'b1;
		pulse_wdt();
		repeat (60) @(posedge core_clk);
		sleep_active <= 1'b0;
		rd(8'h01, 8'h00, "status");
		chk("pc kept", 16'(last_pc), 16'h0004);
		rd(8'h03, 8'h04, "mask kept");
		$display("test wake done");
		cfg <= '{RESISTOR_CAP_OSC_MODE, 1'b1, 1'b1};
		wr(8'h00, 8'h03);
		slow_run <= 1'b0;
		brownout_det_raw <= 1'b1;
		repeat (30) @(posedge core_clk);
		chk("brown-out hold", 16'(core_reset_hold), 16'h0001);
		brownout_det_raw <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk("delay hold", 16'(core_reset_hold), 16'h0001);
		brownout_det_raw <= 1'b1;
		repeat (5) @(posedge core_clk);
		brownout_det_raw <= 1'b0;
		slow_run <= 1'b1;
		wait_rel(300);
		rd(8'h00, 8'h02, "cause");
		rd(8'h01, 8'h18, "status");
		cfg <= '{RESISTOR_CAP_OSC_MODE, 1'b0, 1'b1};
		brownout_det_raw <= 1'b1;
		repeat (30) @(posedge core_clk);
		chk("brown-out off", 16'(core_reset_hold), 16'h0000);
		brownout_det_raw <= 1'b0;
		$display("test brown-out done");
		clk_en <= 1'b0;
		master_clear_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk("frozen hold", 16'(core_reset_hold), 16'h0000);
		clk_en <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk("clear hold", 16'(core_reset_hold), 16'h0001);
		master_clear_n <= 1'b1;
		wait_rel(6);
		$display("test clock enable done");
		wrap_up();
	end
endmodule
